// ===== hw/usfb_cfg.svh
// Purpose: offsets, field positions and reset values of the serial block
// Assumes: byte-wide registers at their printed addresses
// Notes:   included by its bare name
`ifndef USFB_CFG_SVH
`define USFB_CFG_SVH
`define USFB_ADDR_TX_BUF   16'hfd20
`define USFB_ADDR_RX_BUF   16'hfd22
`define USFB_ADDR_FRAME    16'hfd28
`define USFB_ADDR_DIV_LO   16'hfd2c
`define USFB_ADDR_PSR      16'hfd2e
`define USFB_ADDR_STATUS   16'hfd30
`define USFB_REG_RESET     8'h00
`define USFB_PSC_HI        7
`define USFB_PSC_LO        3
`define USFB_DIVH_HI       2
`define USFB_FR_CHAR_HI    1
`define USFB_FR_STOP       2
`define USFB_FR_NINTH      3
`define USFB_FR_PSEL_HI    5
`define USFB_FR_PSEL_LO    4
`define USFB_FR_PEN        6
`define USFB_OVERSAMPLE    4'hf
`define USFB_MID_SAMPLE    4'h7
`define USFB_FIFO_DEPTH    8
`endif

// ===== hw/usfb_pkg.sv
// Purpose: shared types of the serial block
// Assumes: constants live in usfb_cfg.svh
// Notes:   encodings of the frame fields
`default_nettype none
package usfb_pkg;
  typedef enum logic [1:0] {
    CHAR_EIGHT = 2'h0,
    CHAR_SEVEN = 2'h1,
    CHAR_NINE  = 2'h2,
    CHAR_LOOP  = 2'h3
  } usfb_char_e;
  typedef enum logic [1:0] {
    PAR_ODD   = 2'h0,
    PAR_EVEN  = 2'h1,
    PAR_MARK  = 2'h2,
    PAR_SPACE = 2'h3
  } usfb_par_e;
  typedef enum {TX_IDLE, TX_RUN} usfb_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_BITS} usfb_rx_e;
endpackage
`default_nettype wire

// ===== hw/usfb_fifo.sv
// Purpose: small queue of transmit characters
// Assumes: one clock, push and pop by valid and ready
// Notes:   output word comes from the register array
`default_nettype none
module usfb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // full and empty taken straight from the fill count
  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // storage needs no reset, only the pointers and the fill count do
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // pointers wrap because depth is a power of two
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== hw/usfb_top.sv
// Purpose: frame, baud and data-buffer registers of a serial transceiver
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   transmit characters queue in an eight-word fifo
//
// Local design decision: the strobed register port.
`include "usfb_cfg.svh"
`default_nettype none
// Summary of operation
// - prescaler register: select high, divisor top low
// - divisor register gives low eight divisor bits
// - config registers clear to zero on reset
// - length field picks eight, seven, nine, loopback
// - stop select sends one or two stops
// - ninth-bit control sent only in nine-bit frames
// - parity type odd, even, mark, space
// - parity enable adds parity, ignored nine-bit
// - transmit buffer is writable and readable
// - receive buffer read-only, writes ignored
// - select zero stops clock, else (k+1)/2
// - bit rate is clock/(16*(div+1)*factor)
// - loopback feeds transmit line into receiver
module usfb_top (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out
);
  logic [7:0]  tx_char_buffer_ff;
  logic [7:0]  rx_char_buffer_ff;
  logic [7:0]  frame_format_reg_ff;
  logic [7:0]  divisor_low_reg_ff;
  logic [7:0]  prescale_reg_ff;
  logic [7:0]  rdata_ff;
  logic        rx_full_ff;
  logic        par_err_ff;
  logic        frm_err_ff;
  logic [4:0]  prescale_select;
  logic [10:0] baud_divisor;
  logic [1:0]  char_len;
  logic        stop_bit_count;
  logic        tx_ninth_bit;
  logic [1:0]  par_type;
  logic        parity_enable;
  logic        nine_bit;
  logic        use_par;
  logic        loopback;
  logic [3:0]  n_data;
  logic        wr_tx;
  logic        fifo_ready;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_data;
  logic [5:0]  pre_acc_ff;
  logic        pre_tick_ff;
  logic [10:0] div_cnt_ff;
  logic        tick16_ff;
  logic        in_meta_ff;
  logic        in_sync_ff;
  logic        rx_line;
  usfb_pkg::usfb_tx_e tx_state_ff;
  logic [11:0] tx_shift_ff;
  logic [11:0] tx_frame;
  logic [3:0]  tx_len;
  logic [3:0]  tx_bits_ff;
  logic [3:0]  tx_tick_ff;
  logic        tx_line_ff;
  logic        tx_par_bit;
  usfb_pkg::usfb_rx_e rx_state_ff;
  logic [3:0]  rx_tick_ff;
  logic [3:0]  rx_idx_ff;
  logic [9:0]  rx_sh_ff;
  logic        rx_done;
  logic        rx_par_exp;
  logic        rx_stop_ok;

  // register fields
  assign prescale_select = prescale_reg_ff[`USFB_PSC_HI:`USFB_PSC_LO];
  assign baud_divisor    = {prescale_reg_ff[`USFB_DIVH_HI:0],
                            divisor_low_reg_ff};
  assign char_len        = frame_format_reg_ff[`USFB_FR_CHAR_HI:0];
  assign stop_bit_count  = frame_format_reg_ff[`USFB_FR_STOP];
  assign tx_ninth_bit    = frame_format_reg_ff[`USFB_FR_NINTH];
  assign par_type = frame_format_reg_ff[`USFB_FR_PSEL_HI:`USFB_FR_PSEL_LO];
  assign parity_enable   = frame_format_reg_ff[`USFB_FR_PEN];

  // frame shape decoded once for both directions
  assign nine_bit = (char_len == usfb_pkg::CHAR_NINE) ||
                    (char_len == usfb_pkg::CHAR_LOOP);
  assign loopback = (char_len == usfb_pkg::CHAR_LOOP);
  assign n_data   = nine_bit ? 4'h9 :
                    (char_len == usfb_pkg::CHAR_SEVEN) ? 4'h7 : 4'h8;
  assign use_par  = parity_enable && !nine_bit;

  // writes to the tx address are refused while the queue is full
  assign wr_tx = wr_in && (addr_in == `USFB_ADDR_TX_BUF) && fifo_ready;

  // configuration registers; no write path exists to the rx buffer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_format_reg_ff <= `USFB_REG_RESET;
      divisor_low_reg_ff  <= `USFB_REG_RESET;
      prescale_reg_ff     <= `USFB_REG_RESET;
      tx_char_buffer_ff   <= `USFB_REG_RESET;
    end else begin
      if (wr_tx) tx_char_buffer_ff <= wdata_in;
      if (wr_in && addr_in == `USFB_ADDR_FRAME) begin
        frame_format_reg_ff <= {1'b0, wdata_in[6:0]};  // bit 7 reserved
      end
      if (wr_in && addr_in == `USFB_ADDR_DIV_LO) begin
        divisor_low_reg_ff <= wdata_in;
      end
      if (wr_in && addr_in == `USFB_ADDR_PSR) begin
        prescale_reg_ff <= wdata_in;
      end
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_ff <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `USFB_ADDR_TX_BUF: rdata_ff <= tx_char_buffer_ff;
        `USFB_ADDR_RX_BUF: rdata_ff <= rx_char_buffer_ff;
        `USFB_ADDR_FRAME:  rdata_ff <= frame_format_reg_ff;
        `USFB_ADDR_DIV_LO: rdata_ff <= divisor_low_reg_ff;
        `USFB_ADDR_PSR:    rdata_ff <= prescale_reg_ff;
        `USFB_ADDR_STATUS: rdata_ff <= {3'h0, tx_state_ff ==
                            usfb_pkg::TX_RUN, frm_err_ff, par_err_ff,
                            rx_full_ff, !fifo_ready};
        default:           rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign rdata_out = rdata_ff;

  // status flags; a new event beats the clear by read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_full_ff <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end else begin
      if (rx_done) rx_full_ff <= 1'b1;
      else if (rd_in && addr_in == `USFB_ADDR_RX_BUF) rx_full_ff <= 1'b0;
      if (rx_done && use_par && rx_sh_ff[n_data] != rx_par_exp) begin
        par_err_ff <= 1'b1;
      end else if (rd_in && addr_in == `USFB_ADDR_STATUS) begin
        par_err_ff <= 1'b0;
      end
      if (rx_done && !rx_stop_ok) frm_err_ff <= 1'b1;
      else if (rd_in && addr_in == `USFB_ADDR_STATUS) frm_err_ff <= 1'b0;
    end
  end

  // half-step prescaler: add 2 per clock, wrap at k+1, mean (k+1)/2
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_acc_ff  <= 6'h00;
      pre_tick_ff <= 1'b0;
    end else if (prescale_select == 5'h00) begin
      pre_acc_ff  <= 6'h00;
      pre_tick_ff <= 1'b0;
    end else if (pre_acc_ff + 6'h02 >= {1'b0, prescale_select} + 6'h01) begin
      pre_acc_ff  <= pre_acc_ff + 6'h01 - {1'b0, prescale_select};
      pre_tick_ff <= 1'b1;
    end else begin
      pre_acc_ff  <= pre_acc_ff + 6'h02;
      pre_tick_ff <= 1'b0;
    end
  end

  // divisor stage; one tick16 per divisor+1 prescaler ticks
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_ff <= 11'h000;
      tick16_ff  <= 1'b0;
    end else if (pre_tick_ff && div_cnt_ff >= baud_divisor) begin
      div_cnt_ff <= 11'h000;
      tick16_ff  <= 1'b1;
    end else begin
      if (pre_tick_ff) div_cnt_ff <= div_cnt_ff + 11'h001;
      tick16_ff <= 1'b0;
    end
  end

  // pin synchroniser; only the second stage is read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_meta_ff <= 1'b1;
      in_sync_ff <= 1'b1;
    end else begin
      in_meta_ff <= serial_in_pin_in;
      in_sync_ff <= in_meta_ff;
    end
  end
  assign rx_line = loopback ? tx_line_ff : in_sync_ff;

  usfb_fifo #(
    .WIDTH (8),
    .DEPTH (`USFB_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (wr_tx),
    .in_ready_out  (fifo_ready),
    .in_data_in    (wdata_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // transmit parity and frame image, lsb first, idle ones above
  always_comb begin
    tx_par_bit = 1'b0;
    case (par_type)
      usfb_pkg::PAR_ODD:  tx_par_bit = (char_len == usfb_pkg::CHAR_SEVEN) ?
                                       ~^fifo_data[6:0] : ~^fifo_data;
      usfb_pkg::PAR_EVEN: tx_par_bit = (char_len == usfb_pkg::CHAR_SEVEN) ?
                                       ^fifo_data[6:0] : ^fifo_data;
      usfb_pkg::PAR_MARK: tx_par_bit = 1'b1;
      default:            tx_par_bit = 1'b0;
    endcase
    tx_frame = 12'hfff;
    tx_frame[0] = 1'b0;
    tx_frame[8:1] = fifo_data;
    if (nine_bit) begin
      tx_frame[9] = tx_ninth_bit;
    end else if (char_len == usfb_pkg::CHAR_SEVEN) begin
      tx_frame[8] = use_par ? tx_par_bit : 1'b1;
    end else begin
      tx_frame[9] = use_par ? tx_par_bit : 1'b1;
    end
    tx_len = 4'h1 + n_data + {3'h0, use_par} +
             (stop_bit_count ? 4'h2 : 4'h1);
  end

  // the shifter pops the queue only on a tick16 while idle
  assign fifo_pop = (tx_state_ff == usfb_pkg::TX_IDLE) && tick16_ff &&
                    fifo_valid;

  // transmitter: sixteen ticks per bit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_ff <= usfb_pkg::TX_IDLE;
      tx_shift_ff <= 12'hfff;
      tx_bits_ff  <= 4'h0;
      tx_tick_ff  <= 4'h0;
      tx_line_ff  <= 1'b1;
    end else begin
      case (tx_state_ff)
        usfb_pkg::TX_IDLE: begin
          tx_line_ff <= 1'b1;
          if (fifo_pop) begin
            tx_shift_ff <= tx_frame;
            tx_bits_ff  <= tx_len;
            tx_tick_ff  <= 4'h0;
            tx_line_ff  <= 1'b0;
            tx_state_ff <= usfb_pkg::TX_RUN;
          end
        end
        usfb_pkg::TX_RUN: begin
          if (tick16_ff) begin
            tx_tick_ff <= tx_tick_ff + 4'h1;
            if (tx_tick_ff == `USFB_OVERSAMPLE) begin
              tx_shift_ff <= {1'b1, tx_shift_ff[11:1]};
              tx_line_ff  <= tx_shift_ff[1];
              tx_bits_ff  <= tx_bits_ff - 4'h1;
              if (tx_bits_ff == 4'h1) begin
                tx_line_ff  <= 1'b1;
                tx_state_ff <= usfb_pkg::TX_IDLE;
              end
            end
          end
        end
        default: tx_state_ff <= usfb_pkg::TX_IDLE;
      endcase
    end
  end

  // pin stays idle while the line is looped inside
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) serial_out_pin_out <= 1'b1;
    else serial_out_pin_out <= loopback ? 1'b1 : tx_line_ff;
  end

  // receive parity expected from the collected data bits
  always_comb begin
    case (par_type)
      usfb_pkg::PAR_ODD:  rx_par_exp = (char_len == usfb_pkg::CHAR_SEVEN) ?
                                       ~^rx_sh_ff[6:0] : ~^rx_sh_ff[7:0];
      usfb_pkg::PAR_EVEN: rx_par_exp = (char_len == usfb_pkg::CHAR_SEVEN) ?
                                       ^rx_sh_ff[6:0] : ^rx_sh_ff[7:0];
      usfb_pkg::PAR_MARK: rx_par_exp = 1'b1;
      default:            rx_par_exp = 1'b0;
    endcase
  end

  // last sample of a frame is the stop bit
  assign rx_done    = (rx_state_ff == usfb_pkg::RX_BITS) && tick16_ff &&
                      rx_tick_ff == `USFB_OVERSAMPLE &&
                      rx_idx_ff == n_data + {3'h0, use_par};
  assign rx_stop_ok = rx_line;

  // receiver: find start edge, check mid start, sample mid bits
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state_ff <= usfb_pkg::RX_IDLE;
      rx_tick_ff  <= 4'h0;
      rx_idx_ff   <= 4'h0;
      rx_sh_ff    <= 10'h000;
    end else if (tick16_ff) begin
      rx_tick_ff <= rx_tick_ff + 4'h1;
      case (rx_state_ff)
        usfb_pkg::RX_IDLE: begin
          rx_tick_ff <= 4'h0;
          if (!rx_line) rx_state_ff <= usfb_pkg::RX_START;
        end
        usfb_pkg::RX_START: begin
          if (rx_tick_ff == `USFB_MID_SAMPLE) begin
            rx_tick_ff  <= 4'h0;
            rx_idx_ff   <= 4'h0;
            rx_state_ff <= rx_line ? usfb_pkg::RX_IDLE : usfb_pkg::RX_BITS;
          end
        end
        usfb_pkg::RX_BITS: begin
          if (rx_tick_ff == `USFB_OVERSAMPLE) begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff < 4'ha) rx_sh_ff[rx_idx_ff] <= rx_line;
            if (rx_done) rx_state_ff <= usfb_pkg::RX_IDLE;
          end
        end
        default: rx_state_ff <= usfb_pkg::RX_IDLE;
      endcase
    end
  end

  // received character; seven-bit frames read with bit 7 clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_char_buffer_ff <= 8'h00;
    end else if (rx_done) begin
      rx_char_buffer_ff <= (char_len == usfb_pkg::CHAR_SEVEN) ?
                           {1'b0, rx_sh_ff[6:0]} : rx_sh_ff[7:0];
    end
  end

  // every check below is muted while reset is held
  default disable iff (!rstn_in);

  a_psr_read: assert property (@(posedge clk_in)
    rd_in && addr_in == `USFB_ADDR_PSR |=>
    rdata_out[7:3] == prescale_select && rdata_out[2:0] == baud_divisor[10:8])
    else $error("prescaler read mismatch");
  a_div_read: assert property (@(posedge clk_in)
    wr_in && addr_in == `USFB_ADDR_DIV_LO ##1 rd_in &&
    addr_in == `USFB_ADDR_DIV_LO |=> rdata_out == $past(wdata_in, 2))
    else $error("divisor low read mismatch");
  a_cfg_reset: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> frame_format_reg_ff == 8'h00 &&
    prescale_reg_ff == 8'h00 && divisor_low_reg_ff == 8'h00)
    else $error("config not clear after reset");
  a_frame_len: assert property (@(posedge clk_in)
    fifo_pop && !use_par && char_len == usfb_pkg::CHAR_EIGHT |=>
    tx_bits_ff == (stop_bit_count ? 4'hb : 4'ha))
    else $error("frame length wrong");
  a_ninth_bit: assert property (@(posedge clk_in)
    fifo_pop && nine_bit |=> tx_shift_ff[9] == $past(tx_ninth_bit))
    else $error("ninth bit not sent");
  a_par_bit: assert property (@(posedge clk_in)
    fifo_pop && use_par && par_type == usfb_pkg::PAR_EVEN &&
    char_len == usfb_pkg::CHAR_EIGHT |=> ^tx_shift_ff[9:1] == 1'b0)
    else $error("even parity wrong");
  a_tx_write: assert property (@(posedge clk_in)
    wr_tx ##1 rd_in && addr_in == `USFB_ADDR_TX_BUF |=>
    rdata_out == $past(wdata_in, 2))
    else $error("tx buffer readback wrong");
  a_rx_readonly: assert property (@(posedge clk_in)
    wr_in && !rx_done |=> $stable(rx_char_buffer_ff))
    else $error("rx buffer changed by write");
  // three zero cycles: a tick already in the pipe may still drain
  a_no_clock: assert property (@(posedge clk_in)
    prescale_select == 5'h00 ##1 prescale_select == 5'h00 ##1
    prescale_select == 5'h00 |-> !pre_tick_ff && !tick16_ff)
    else $error("clock runs with select zero");
  a_loop_route: assert property (@(posedge clk_in)
    loopback |-> rx_line == tx_line_ff ##1 serial_out_pin_out)
    else $error("loopback path wrong");
  a_seven_top: assert property (@(posedge clk_in)
    rx_done && char_len == usfb_pkg::CHAR_SEVEN |=> !rx_char_buffer_ff[7])
    else $error("seven-bit top bit set");
endmodule
`default_nettype wire

// ===== test/usfb_peer.sv
// Purpose: remote serial peer that records and sends frames
// Assumes: bit time in clock cycles is set by the bench
// Notes:   records raw bits after the start bit, lsb first
`default_nettype none
module usfb_peer (
  input  wire logic        clk_in,
  input  wire logic        line_in,
  input  wire logic [15:0] bit_cyc_in,
  input  wire logic [3:0]  nbits_in,
  output logic             line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] got_q[$];
  int          gap_q[$];
  int          cyc;
  int          last;
  logic [11:0] w;
  // free cycle count, used to measure the gap between start bits
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_in);
      cyc++;
    end
  end
  // sample mid-bit like a real receiver, so jitter does not matter
  initial begin
    line_out = 1'b1;
    last = 0;
    forever begin
      @(negedge line_in);
      gap_q.push_back(cyc - last);
      last = cyc;
      w = 12'h000;
      repeat (bit_cyc_in / 2) @(posedge clk_in);
      for (int i = 0; i < 12; i++) begin
        if (i < nbits_in) begin
          repeat (bit_cyc_in) @(posedge clk_in);
          w[i] = line_in;
        end
      end
      got_q.push_back(w);
    end
  end
  // one frame: start, data lsb first, one stop, then idle high
  task automatic send(input logic [8:0] d, input int nb);
    logic [9:0] sh;
    sh = {d, 1'b0};
    @(posedge clk_in);
    for (int i = 0; i < nb + 2; i++) begin
      line_out <= (i == nb + 1) ? 1'b1 : sh[i];
      repeat (bit_cyc_in) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ===== test/usfb_top_tb_top.sv
// Purpose: self-checking bench of the serial config and buffer block
// Assumes: peer model on the serial pins, register port driven here
// Notes:   bit time 16 clocks unless a scenario changes the prescaler
`include "usfb_cfg.svh"
`default_nettype none
module usfb_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        rstn_in;
  logic [15:0] addr_in;
  logic [7:0]  wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  rdata_out;
  logic        sin;
  logic        sout;
  logic [15:0] bit_cyc;
  logic [3:0]  nbits;
  int          miscompares;
  int          check_count;
  usfb_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .serial_in_pin_in(sin),
    .serial_out_pin_out(sout));
  usfb_peer peer (.clk_in(clk_in), .line_in(sout), .bit_cyc_in(bit_cyc),
    .nbits_in(nbits), .line_out(sin));
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe; called just
  // after an edge, so a read may follow a write with no gap
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({4'h0, d}, {4'h0, e});
  endtask
  // poll a status bit, bounded so a stuck flag ends the run
  task automatic wait_stat(input int b, input logic v);
    logic [7:0] s;
    int         k;
    k = 0;
    rd(`USFB_ADDR_STATUS, s);
    while (s[b] !== v && k < 3000) begin
      rd(`USFB_ADDR_STATUS, s);
      k++;
    end
    if (k == 3000) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (peer.got_q.size() < n && k < 20000) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 20000) begin
      miscompares++;
      final_report();
    end
  endtask
  // expected line bits after start: data, parity, stops
  function automatic logic [11:0] frame(input logic [7:0] fr,
                                        input logic [7:0] c,
                                        output logic [3:0] n);
    logic [11:0] v;
    logic [8:0]  dd;
    logic        p;
    int          nd;
    v  = 12'h000;
    dd = {fr[3], c};
    nd = (fr[1:0] == 2'h1) ? 7 : (fr[1] ? 9 : 8);
    for (int i = 0; i < 9; i++) begin
      if (i < nd) v[i] = dd[i];
    end
    p = ^(c & ((nd == 7) ? 8'h7f : 8'hff));
    p = fr[5] ? ~fr[4] : (p ^ ~fr[4]);
    if (fr[6] && !fr[1]) begin
      v[nd] = p;
      nd++;
    end
    v[nd] = 1'b1;
    nd = nd + 1 + int'(fr[2]);
    v[nd-1] = 1'b1;
    n = nd[3:0];
    return v;
  endfunction
  task automatic wait_idle();
    wait_stat(4, 1'b0);
  endtask
  // two queued characters, checked bit by bit and start to start
  task automatic pair(input logic [7:0] fr, input int bc);
    logic [11:0] e0;
    logic [11:0] e1;
    logic [3:0]  n;
    int          g;
    e0 = frame(fr, 8'h96, n);
    e1 = frame(fr, 8'h3b, n);
    nbits   <= n;
    bit_cyc <= 16'(bc);
    wr(`USFB_ADDR_FRAME, fr);
    wr(`USFB_ADDR_TX_BUF, 8'h96);
    wr(`USFB_ADDR_TX_BUF, 8'h3b);
    wait_frames(2);
    chk(peer.got_q.pop_front(), e0);
    chk(peer.got_q.pop_front(), e1);
    g = peer.gap_q.pop_back();
    peer.gap_q.delete();
    chk(12'(g >= (n+1)*bc && g <= (n+1)*bc + bc/8 + 4), 12'h001);
    wait_idle();
  endtask
  task automatic t_regs();
    rd_chk(`USFB_ADDR_FRAME, 8'h00);
    rd_chk(`USFB_ADDR_DIV_LO, 8'h00);
    rd_chk(`USFB_ADDR_PSR, 8'h00);
    rd_chk(16'hfd24, 8'h00);
    wr(`USFB_ADDR_PSR, 8'ha5);
    rd_chk(`USFB_ADDR_PSR, 8'ha5);
    wr(`USFB_ADDR_DIV_LO, 8'h3c);
    rd_chk(`USFB_ADDR_DIV_LO, 8'h3c);
    wr(`USFB_ADDR_FRAME, 8'hff);
    rd_chk(`USFB_ADDR_FRAME, 8'h7f);
    wr(`USFB_ADDR_DIV_LO, 8'h00);
    wr(`USFB_ADDR_PSR, 8'h08);
  endtask
  task automatic t_formats();
    logic [7:0] cfg [12] = '{8'h00, 8'h01, 8'h0a, 8'h02, 8'h40, 8'h50,
                             8'h60, 8'h70, 8'h41, 8'h64, 8'h4a, 8'h31};
    for (int k = 0; k < 12; k++) pair(cfg[k], 16);
  endtask
  // select 1, 2 and 3 with divisor 0, 0 and 1 give 16, 24, 64 clocks
  task automatic t_baud();
    logic [7:0] ps [3] = '{8'h08, 8'h10, 8'h18};
    logic [7:0] dl [3] = '{8'h00, 8'h00, 8'h01};
    int         bc [3] = '{16, 24, 64};
    for (int k = 0; k < 3; k++) begin
      wr(`USFB_ADDR_PSR, ps[k]);
      wr(`USFB_ADDR_DIV_LO, dl[k]);
      pair(8'h00, bc[k]);
    end
    wr(`USFB_ADDR_PSR, 8'h08);
    wr(`USFB_ADDR_DIV_LO, 8'h00);
  endtask
  // stopped clock holds the queue; fill it past full, then drain
  task automatic t_fifo();
    logic [7:0] s;
    logic [3:0] n;
    wr(`USFB_ADDR_PSR, 8'h00);
    for (int k = 0; k < 9; k++) wr(`USFB_ADDR_TX_BUF, 8'h10 + 8'(k));
    rd(`USFB_ADDR_STATUS, s);
    chk({11'h000, s[0]}, 12'h001);
    rd_chk(`USFB_ADDR_TX_BUF, 8'h17);
    repeat (300) @(posedge clk_in);
    chk(12'(peer.got_q.size()), 12'h000);
    nbits   <= 4'h9;
    bit_cyc <= 16'h0010;
    wr(`USFB_ADDR_PSR, 8'h08);
    wait_frames(8);
    wait_idle();
    chk(12'(peer.got_q.size()), 12'h008);
    for (int k = 0; k < 8; k++) begin
      chk(peer.got_q.pop_front(), frame(8'h00, 8'h10 + 8'(k), n));
    end
    peer.gap_q.delete();
  endtask
  task automatic t_rx();
    wr(`USFB_ADDR_FRAME, 8'h00);
    peer.send(9'h0c5, 8);
    wait_stat(1, 1'b1);
    rd_chk(`USFB_ADDR_RX_BUF, 8'hc5);
    wr(`USFB_ADDR_RX_BUF, 8'h00);
    rd_chk(`USFB_ADDR_RX_BUF, 8'hc5);
    wr(`USFB_ADDR_FRAME, 8'h01);
    peer.send(9'h1aa, 7);
    wait_stat(1, 1'b1);
    rd_chk(`USFB_ADDR_RX_BUF, 8'h2a);
  endtask
  // loopback keeps the pin idle and feeds the receiver
  task automatic t_loop();
    wr(`USFB_ADDR_FRAME, 8'h03);
    wr(`USFB_ADDR_TX_BUF, 8'ha6);
    wait_stat(1, 1'b1);
    rd_chk(`USFB_ADDR_RX_BUF, 8'ha6);
    chk(12'(peer.got_q.size()), 12'h000);
  endtask
  // reset for 16 cycles, then every scenario in turn
  initial begin
    miscompares = 0;
    check_count = 0;
    rstn_in  = 1'b0;
    addr_in  = 16'h0000;
    wdata_in = 8'h00;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    bit_cyc  = 16'h0010;
    nbits    = 4'h9;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_formats();
    t_baud();
    t_fifo();
    t_rx();
    t_loop();
    final_report();
  end
endmodule
`default_nettype wire
